//--- scdec_decoder.sv
// Purpose : command byte shifter and decoder of a smart card coupler
// Assumes : serial clock, data and chip select sampled by clk_sys_i
// Notes   : bits arrive most significant first
//
// Function
// - byte is three-bit opcode plus five parameters
// - byte accepted only while chip select low
// - card reset pin follows bit four immediately
// - ordinary opcodes: bits one, zero set supply
// - opcode 110 drives aux contacts four, eight
// - opcode 101 sets detect polarity, serial mode
// - ordinary opcodes: clock bits 00 stop clock
// - card presence debounced, nominal 50 microseconds
// - clock bits 01 pass, 10 half, 11 quarter
// - opcode 101 values 0100/0101 select slopes
// - bank mode: opcodes below 100 must match bank pins
`timescale 1ns/1ps
module scdec_decoder #(
    parameter int FILTER_LEN = scdec_pkg::FILTER_CYCLES
) (
    input  wire logic       clk_sys_i,
    input  wire logic       rst_n_i,
    input  wire logic       cs_n_i,
    input  wire logic       sclk_i,
    input  wire logic       mosi_i,
    input  wire logic       bank_mode_i,
    input  wire logic       bank_address_pin_zero_i,
    input  wire logic       bank_address_pin_one_i,
    input  wire logic       card_clk_in_i,
    input  wire logic       card_detect_i,
    output logic            card_reset_pin_o,
    output logic [1:0]      card_supply_o,
    output logic            card_clock_out_o,
    output logic            aux_contact_four_o,
    output logic            aux_contact_eight_o,
    output logic            detect_switch_polarity_o,
    output logic            special_serial_mode_o,
    output logic            fast_edge_slope_o,
    output logic            card_present_o
);
    import scdec_pkg::*;

    // ------------------------------------------------------------
    // serial shifter
    // ------------------------------------------------------------
    logic       sclk_prev, next_sclk_prev;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [7:0] shift, next_shift;
    logic       rst_pin, next_rst_pin;
    logic       byte_done;
    logic [7:0] cmd_byte;

    always_comb begin
        next_sclk_prev = sclk_i;
        next_bit_cnt   = bit_cnt;
        next_shift     = shift;
        next_rst_pin   = rst_pin;
        byte_done      = 1'b0;
        cmd_byte       = {shift[6:0], mosi_i};
        if (cs_n_i) begin
            next_bit_cnt = 4'h0;
        end else if (sclk_i && !sclk_prev) begin
            next_shift = cmd_byte;
            if (bit_cnt == BIT_RST_IDX) begin
                next_rst_pin = mosi_i;
            end
            if (bit_cnt == BIT_LAST) begin
                byte_done    = 1'b1;
                next_bit_cnt = 4'h0;
            end else begin
                next_bit_cnt = bit_cnt + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            sclk_prev <= 1'b0;
            bit_cnt   <= 4'h0;
            shift     <= 8'h00;
            rst_pin   <= 1'b0;
        end else begin
            sclk_prev <= next_sclk_prev;
            bit_cnt   <= next_bit_cnt;
            shift     <= next_shift;
            rst_pin   <= next_rst_pin;
        end
    end

    // ------------------------------------------------------------
    // command decode and settings
    // ------------------------------------------------------------
    logic [2:0] opcode;
    logic [4:0] param;
    logic       bank_ok, ordinary;
    logic [1:0] supply, next_supply;
    logic [1:0] clk_sel, next_clk_sel;
    logic       aux4, next_aux4, aux8, next_aux8;
    logic       det_nc, next_det_nc, ser_spec, next_ser_spec;
    logic       slope_fast, next_slope_fast;

    always_comb begin
        opcode   = cmd_byte[OP_HI:OP_LO];
        param    = cmd_byte[PRM_HI:0];
        ordinary = (opcode != OP_SYNC_DRIVE) && (opcode != OP_CONFIG)
                   && (opcode != OP_RESERVED);
        bank_ok  = !bank_mode_i || (opcode >= OP_EXT_ASYNC)
                   || (opcode[1:0] == {bank_address_pin_one_i,
                                       bank_address_pin_zero_i});
        next_supply     = supply;
        next_clk_sel    = clk_sel;
        next_aux4       = aux4;
        next_aux8       = aux8;
        next_det_nc     = det_nc;
        next_ser_spec   = ser_spec;
        next_slope_fast = slope_fast;
        if (byte_done && bank_ok) begin
            if (ordinary) begin
                next_supply  = param[1:0];
                next_clk_sel = param[3:2];
            end else if (opcode == OP_SYNC_DRIVE) begin
                next_aux4 = param[1];
                next_aux8 = param[0];
            end else if (opcode == OP_CONFIG) begin
                case (param)
                    CFG_DET_NO:     next_det_nc     = 1'b0;
                    CFG_DET_NC:     next_det_nc     = 1'b1;
                    CFG_SER_SPEC:   next_ser_spec   = 1'b1;
                    CFG_SER_NORM:   next_ser_spec   = 1'b0;
                    CFG_SLOPE_SLOW: next_slope_fast = 1'b0;
                    CFG_SLOPE_FAST: next_slope_fast = 1'b1;
                    default:        next_det_nc     = det_nc;
                endcase
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            supply     <= SUPPLY_OFF;
            clk_sel    <= CLK_STOP;
            aux4       <= 1'b0;
            aux8       <= 1'b0;
            det_nc     <= 1'b0;
            ser_spec   <= 1'b0;
            slope_fast <= 1'b0;
        end else begin
            supply     <= next_supply;
            clk_sel    <= next_clk_sel;
            aux4       <= next_aux4;
            aux8       <= next_aux8;
            det_nc     <= next_det_nc;
            ser_spec   <= next_ser_spec;
            slope_fast <= next_slope_fast;
        end
    end

    // ------------------------------------------------------------
    // card clock divider
    // ------------------------------------------------------------
    logic cin_prev, next_cin_prev, div_half, next_div_half;
    logic cclk, next_cclk;

    always_comb begin
        next_cin_prev = card_clk_in_i;
        next_div_half = div_half;
        next_cclk     = cclk;
        case (clk_sel)
            CLK_STOP: begin
                next_cclk     = 1'b0;
                next_div_half = 1'b0;
            end
            CLK_DIV1: next_cclk = card_clk_in_i;
            CLK_DIV2: begin
                if (card_clk_in_i && !cin_prev) begin
                    next_cclk = !cclk;
                end
            end
            default: begin
                if (card_clk_in_i && !cin_prev) begin
                    next_div_half = !div_half;
                    if (div_half) begin
                        next_cclk = !cclk;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            cin_prev <= 1'b0;
            div_half <= 1'b0;
            cclk     <= 1'b0;
        end else begin
            cin_prev <= next_cin_prev;
            div_half <= next_div_half;
            cclk     <= next_cclk;
        end
    end

    // ------------------------------------------------------------
    // card presence filter
    // ------------------------------------------------------------
    logic [FILTER_W-1:0] filt_cnt, next_filt_cnt;
    logic                present, next_present, raw_present;

    always_comb begin
        raw_present   = card_detect_i ^ det_nc;
        next_present  = present;
        next_filt_cnt = '0;
        if (raw_present != present) begin
            if (filt_cnt == FILTER_W'(FILTER_LEN - 1)) begin
                next_present = raw_present;
            end else begin
                next_filt_cnt = filt_cnt + 1'b1;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            filt_cnt <= '0;
            present  <= 1'b0;
        end else begin
            filt_cnt <= next_filt_cnt;
            present  <= next_present;
        end
    end

    assign card_reset_pin_o         = rst_pin;
    assign card_supply_o            = supply;
    assign card_clock_out_o         = cclk;
    assign aux_contact_four_o       = aux4;
    assign aux_contact_eight_o      = aux8;
    assign detect_switch_polarity_o = det_nc;
    assign special_serial_mode_o    = ser_spec;
    assign fast_edge_slope_o        = slope_fast;
    assign card_present_o           = present;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_accept;
        byte_done && bank_ok;
    endsequence
    sequence s_bit_four;
        !cs_n_i && sclk_i && !sclk_prev && bit_cnt == BIT_RST_IDX;
    endsequence

    a_cs_blocks_update: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) cs_n_i |=> $stable(supply) && $stable(aux4))
        else $error("settings changed with chip select high");
    a_reset_follows_b4: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) s_bit_four |=> rst_pin == $past(mosi_i))
        else $error("card reset did not follow bit four");
    a_supply_decode: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) s_accept ##0 ordinary
        |=> supply == $past(cmd_byte[1:0]))
        else $error("supply not taken from bits one and zero");
    a_aux_drive: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) s_accept ##0 opcode == OP_SYNC_DRIVE
        |=> aux4 == $past(cmd_byte[1]) && aux8 == $past(cmd_byte[0]))
        else $error("aux contacts not driven");
    a_detect_pol: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) s_accept ##0 opcode == OP_CONFIG
        ##0 param == CFG_DET_NC |=> det_nc)
        else $error("detect polarity not set");
    a_clock_stop: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) clk_sel == CLK_STOP [*2] |-> !cclk)
        else $error("card clock not held low");
    a_clock_pass: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) clk_sel == CLK_DIV1
        |=> cclk == $past(card_clk_in_i))
        else $error("card clock not passed through");
    a_filter_delay: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) $changed(present)
        |-> $past(filt_cnt) == FILTER_W'(FILTER_LEN - 1))
        else $error("presence changed before filter delay");
    a_slope_fast: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) s_accept ##0 opcode == OP_CONFIG
        ##0 param == CFG_SLOPE_FAST |=> slope_fast)
        else $error("fast slope not selected");
    a_bank_block: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n_i) byte_done && !bank_ok
        |=> $stable(supply) && $stable(clk_sel))
        else $error("command taken despite bank mismatch");
endmodule : scdec_decoder

//--- scdec_decoder_tb.sv
// Purpose : self-checking bench for the command decoder
// Assumes : filter shortened to 8 cycles
// Notes   : card clock input runs at a quarter of clk_sys_i
`timescale 1ns/1ps
module scdec_decoder_tb;
    import scdec_pkg::*;
    localparam int         FLT = 8;
    localparam logic [7:0] CFG [8] = '{8'hA1, 8'hA2, 8'hA5, 8'hA7,
                                       8'hE3, 8'hA0, 8'hA3, 8'hA4};
    logic       clk_sys_i, rst_n_i, bank_mode, pin0, pin1, detect;
    logic       cs_n, sclk, mosi, rst_pin, clk_out, a4, a8, pol, spec;
    logic       fast, present;
    logic       clk_out_q = 1'b0;
    logic [1:0] supply;
    logic [1:0] div_cnt = 2'h0;
    wire        clk_in = div_cnt[1];
    logic [7:0] exp_st;
    int         mismatches, checks_done, edges, k, i, e;
    wire  [7:0] outs = {rst_pin, supply, a4, a8, pol, spec, fast};
    scdec_host host (.clk_i(clk_sys_i), .cs_n_o(cs_n), .sclk_o(sclk),
                     .mosi_o(mosi));
    scdec_decoder #(.FILTER_LEN(FLT)) DUT (
        .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cs_n_i(cs_n),
        .sclk_i(sclk), .mosi_i(mosi), .bank_mode_i(bank_mode),
        .bank_address_pin_zero_i(pin0), .bank_address_pin_one_i(pin1),
        .card_clk_in_i(clk_in), .card_detect_i(detect),
        .card_reset_pin_o(rst_pin), .card_supply_o(supply),
        .card_clock_out_o(clk_out), .aux_contact_four_o(a4),
        .aux_contact_eight_o(a8), .detect_switch_polarity_o(pol),
        .special_serial_mode_o(spec), .fast_edge_slope_o(fast),
        .card_present_o(present));
    // --------------------------------------------------------------
    // clocks, card clock edge counter
    // --------------------------------------------------------------
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    // card clock looked at once settled, after the launching edge
    always @(posedge clk_sys_i) begin
        #1;
        if (clk_out && !clk_out_q) edges++;
        clk_out_q = clk_out;
        div_cnt++;
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        mismatches++;
        report_and_stop();
    end
    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic cmp(input logic [7:0] got, exp, input string what);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask : cmp
    // write one byte and update the expected settings
    task automatic wr(input logic [7:0] b);
        host.send(b, 8);
        exp_st[7] = b[4];
        case (b[7:5])
            OP_SYNC_DRIVE: exp_st[4:3] = b[1:0];
            OP_CONFIG: case (b[4:0])
                CFG_DET_NO:     exp_st[2] = 1'b0;
                CFG_DET_NC:     exp_st[2] = 1'b1;
                CFG_SER_SPEC:   exp_st[1] = 1'b1;
                CFG_SER_NORM:   exp_st[1] = 1'b0;
                CFG_SLOPE_SLOW: exp_st[0] = 1'b0;
                CFG_SLOPE_FAST: exp_st[0] = 1'b1;
                default: ;
            endcase
            OP_RESERVED: ;
            default: if (!(bank_mode && b[7:5] < OP_EXT_ASYNC &&
                           b[6:5] != {pin1, pin0}))
                exp_st[6:5] = b[1:0];
        endcase
    endtask : wr
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : report_and_stop
    // --------------------------------------------------------------
    // tests
    // --------------------------------------------------------------
    initial begin
        {rst_n_i, bank_mode, pin0, pin1, detect} = 5'h00;
        exp_st = 8'h00;
        mismatches = 0;
        checks_done = 0;
        repeat (20) @(posedge clk_sys_i);
        #1 rst_n_i = 1'b1;
        cmp(outs, exp_st, "reset");
        cmp({7'h00, present}, 8'h00, "present reset");
        for (k = 0; k < 4; k++) begin
            wr(8'h90 | 8'(k * 5));
            cmp(outs, exp_st, "supply");
            i = edges;
            repeat (64) @(posedge clk_sys_i);
            e = (k == 0) ? 0 : 16 >> (k - 1);
            i = edges - i;
            cmp({7'h00, i >= e - 1 && i <= e + 1}, 8'h01, "clk");
        end
        $display("test supply and clock done");
        host.send(8'hA0, 4);
        exp_st[7] = 1'b0;
        cmp(outs, exp_st, "abort");
        wr(8'hC2);
        cmp(outs, exp_st, "aux");
        wr(8'hC1);
        cmp(outs, exp_st, "aux");
        $display("test abort and aux done");
        for (k = 0; k < 8; k++) begin
            wr(CFG[k]);
            cmp(outs, exp_st, "config");
        end
        $display("test config done");
        {bank_mode, pin1, pin0} = 3'h5;
        wr(8'h50);
        cmp(outs, exp_st, "bank mismatch");
        wr(8'h3A);
        cmp(outs, exp_st, "bank match");
        bank_mode = 1'b0;
        $display("test bank done");
        detect = 1'b1;
        repeat (5) @(posedge clk_sys_i);
        #1 detect = 1'b0;
        @(posedge clk_sys_i) #1 detect = 1'b1;
        repeat (FLT - 2) @(posedge clk_sys_i);
        cmp({7'h00, present}, 8'h00, "bounce");
        repeat (4) @(posedge clk_sys_i);
        cmp({7'h00, present}, 8'h01, "insert");
        wr(8'hA1);
        repeat (FLT + 2) @(posedge clk_sys_i);
        cmp({7'h00, present}, 8'h00, "polarity");
        $display("test presence done");
        report_and_stop();
    end
endmodule : scdec_decoder_tb

//--- scdec_host.sv
// Purpose : host model that shifts command bytes into the decoder
// Assumes : outputs change 1 ns after the clk_i rising edge
// Notes   : sclk stands low outside frames
`timescale 1ns/1ps
module scdec_host (
    input  wire logic clk_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      mosi_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        mosi_o = 1'b0;
    end
    // top nbits of b, msb first; a short frame is an abort
    task automatic send(input logic [7:0] b, input int nbits);
        int i;
        @(posedge clk_i) #1;
        cs_n_o = 1'b0;
        for (i = 7; i > 7 - nbits; i--) begin
            mosi_o = b[i];
            sclk_o = 1'b0;
            @(posedge clk_i) #1;
            sclk_o = 1'b1;
            @(posedge clk_i) #1;
        end
        sclk_o = 1'b0;
        mosi_o = ~mosi_o;
        @(posedge clk_i) #1;
        cs_n_o = 1'b1;
    endtask : send
endmodule : scdec_host

//--- scdec_pkg.sv
// Purpose : shared constants for the card coupler command decoder
// Assumes : 100 MHz system clock
// Notes   : operation code sits in the top three bits of the byte
package scdec_pkg;
    localparam int          CLK_MHZ        = 100;
    localparam int          FILTER_NOM_US  = 50;
    localparam int          FILTER_CYCLES  = FILTER_NOM_US * CLK_MHZ;
    localparam int          FILTER_W       = 16;
    localparam int          BYTE_BITS      = 8;
    localparam logic [3:0]  BIT_LAST       = 4'h7;
    localparam logic [3:0]  BIT_RST_IDX    = 4'h3;
    localparam int          OP_HI          = 7;
    localparam int          OP_LO          = 5;
    localparam int          PRM_HI         = 4;
    localparam logic [2:0]  OP_EXT_ASYNC   = 3'h4;
    localparam logic [2:0]  OP_CONFIG      = 3'h5;
    localparam logic [2:0]  OP_SYNC_DRIVE  = 3'h6;
    localparam logic [2:0]  OP_RESERVED    = 3'h7;
    localparam logic [1:0]  SUPPLY_OFF     = 2'h0;
    localparam logic [1:0]  CLK_STOP       = 2'h0;
    localparam logic [1:0]  CLK_DIV1       = 2'h1;
    localparam logic [1:0]  CLK_DIV2       = 2'h2;
    localparam logic [1:0]  CLK_DIV4       = 2'h3;
    localparam logic [4:0]  CFG_DET_NO     = 5'h00;
    localparam logic [4:0]  CFG_DET_NC     = 5'h01;
    localparam logic [4:0]  CFG_SER_SPEC   = 5'h02;
    localparam logic [4:0]  CFG_SER_NORM   = 5'h03;
    localparam logic [4:0]  CFG_SLOPE_SLOW = 5'h04;
    localparam logic [4:0]  CFG_SLOPE_FAST = 5'h05;
endpackage : scdec_pkg
